/* hdl/stpd_pkg.sv */
// Package of constants for the stepper translator and diagnostics block.
package stpd_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_POS = 8'h08;
    localparam logic [7:0] OFS_CLR = 8'h0c;
    // Control register fields.
    localparam int CTRL_SENSE = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_TRANSP = 2;
    localparam int CTRL_GAIN = 3;
    localparam int CTRL_RES_LO = 4;
    localparam int CTRL_AMP_LO = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    // Status register fields.
    localparam int ST_TW = 0;
    localparam int ST_TSD = 1;
    localparam int ST_OPEN_WINDING_X = 2;
    localparam int ST_OPEN_WINDING_Y = 3;
    localparam int ST_PUMP = 4;
    localparam int ST_OVCX_LO = 8;
    localparam int ST_OVCY_LO = 12;
    localparam int ST_DRV_OFF = 16;
    // Resolution code: shift of the step size in 1/32 units, 0 = 1/32 .. 5 = full step.
    localparam logic [2:0] RES_RESET = 3'h0;
    localparam logic [4:0] AMP_RESET = 5'h00;
    // Timing.
    localparam int unsigned OPEN_MS = 200;
    localparam int unsigned OPEN_CYC = OPEN_MS * 1000 * CLK_MHZ;
    localparam int unsigned POR_US = 10;
    localparam int unsigned POR_CYC = POR_US * CLK_MHZ;
    localparam int unsigned PWM_CYC = 1000;
endpackage

/* hdl/stpd_sync_if.sv */
// Interface carrying synchronised pin levels from the input stage to the core.
`timescale 1ns/1ns
interface stpd_sync_if;
    logic step;
    logic sense;
    logic [5:0] pins;
    modport src (output step, output sense, output pins);
    modport dst (input step, input sense, input pins);
endinterface

/* hdl/stpd_sync.sv */
// Two-flop synchroniser stage for the step, sense, sample-hold, pump-low, full-duty and zero-cross inputs.
`timescale 1ns/1ns
module stpd_sync
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] raw,
    stpd_sync_if.src o
);
    typedef struct packed
    {
        logic [7:0] s1;
        logic [7:0] s2;
    } stpd_sync_s;
    stpd_sync_s st_r;
    stpd_sync_s st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        if (ce)
        begin
            st_nxt.s1 = raw;
            st_nxt.s2 = st_r.s1;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            // The pump-low pin reads as failing until a real level has passed both stages.
            st_r.s1[3] <= 1'b1;
            st_r.s2[3] <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign o.step = st_r.s2[0];
    assign o.sense = st_r.s2[1];
    assign o.pins = st_r.s2[7:2];
endmodule // stpd_sync

/* hdl/stpd_top.sv */
// Step translator, back-EMF monitor control and fault diagnostics with AXI4-Lite registers.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module stpd_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic next_step_input,
    input wire logic rotation_sense_input,
    input wire logic temp_warn_in,
    input wire logic temp_shutdown_in,
    input wire logic pump_low_in,
    input wire logic full_duty_x_in,
    input wire logic full_duty_y_in,
    input wire logic pwm_sample_hold,
    input wire logic [3:0] overcurrent_x_in,
    input wire logic [3:0] overcurrent_y_in,
    input wire logic pwm_period_start,
    input wire logic zero_cross_x,
    input wire logic zero_cross_y,
    input wire logic [7:0] coil_voltage,
    output logic [6:0] translator_position,
    output logic [4:0] peak_amplitude_code,
    output logic [7:0] backemf_monitor,
    output logic backemf_sample,
    output logic drive_x_en,
    output logic drive_y_en,
    output logic fault_out_n,
    output logic power_on_reset_out_n_o,
    output logic power_on_reset_out_n_oe,
    input wire logic [stpd_pkg::CTRL_RES_LO:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [stpd_pkg::CTRL_RES_LO:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import stpd_pkg::*;

    typedef struct packed
    {
        logic [31:0] ctrl;
        logic [2:0] res_act;
        logic [6:0] pos;
        logic [4:0] amp;
        logic step_d;
        logic tw;
        logic thermal_shutdown_flag;
        logic [3:0] ovcx;
        logic [3:0] ovcy;
        logic open_winding_x;
        logic open_winding_y;
        logic pump;
        logic [27:0] cntx;
        logic [27:0] cnty;
        logic [11:0] por_cnt;
        logic [7:0] bemf;
        logic [7:0] bhold;
        logic smp;
        logic zx_d;
        logic zy_d;
        logic aw_got;
        logic w_got;
        logic [4:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
    } stpd_top_s;

    stpd_top_s st_r;
    stpd_top_s st_nxt;
    stpd_sync_if sy ();

    stpd_sync u_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .raw({zero_cross_y, zero_cross_x, full_duty_y_in, full_duty_x_in, pump_low_in,
            pwm_sample_hold, rotation_sense_input, next_step_input}),
        .o(sy)
    );

    // Step size in 1/32 units for a resolution code.
    function automatic logic [6:0] step_of(input logic [2:0] res);
        step_of = 7'h01 << res;
    endfunction

    // Snap to the nearest grid point of a finer grid, ties rounding up.
    function automatic logic [6:0] snap(input logic [6:0] p, input logic [2:0] res);
        logic [6:0] m;
        logic [6:0] half;
        m = step_of(res) - 7'h01;
        half = step_of(res) >> 1;
        snap = (p + half) & ~m;
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                old[8*i +: 8] = d[8*i +: 8];
            end
        end
        byte_merge = old;
    endfunction

    logic step_edge;
    logic [2:0] res_new;
    logic drv_off;
    logic [31:0] status_word;
    logic [7:0] scaled;

    assign res_new = (st_r.ctrl[CTRL_RES_LO +: 3] > 3'h5) ? 3'h5 : st_r.ctrl[CTRL_RES_LO +: 3];
    // Rising edge when polarity bit is one, falling edge otherwise.
    assign step_edge = st_r.ctrl[CTRL_POL] ? (sy.step & ~st_r.step_d)
        : (~sy.step & st_r.step_d);
    assign drv_off = st_r.thermal_shutdown_flag | (|st_r.ovcx) | (|st_r.ovcy);
    // Coil voltage is divided by two or four before reaching the monitor.
    assign scaled = st_r.ctrl[CTRL_GAIN] ? {2'h0, coil_voltage[7:2]}
        : {1'h0, coil_voltage[7:1]};

    always_comb
    begin
        status_word = '0;
        status_word[ST_TW] = st_r.tw;
        status_word[ST_TSD] = st_r.thermal_shutdown_flag;
        status_word[ST_OPEN_WINDING_X] = st_r.open_winding_x;
        status_word[ST_OPEN_WINDING_Y] = st_r.open_winding_y;
        status_word[ST_PUMP] = st_r.pump;
        status_word[ST_OVCX_LO +: 4] = st_r.ovcx;
        status_word[ST_OVCY_LO +: 4] = st_r.ovcy;
        status_word[ST_DRV_OFF] = drv_off;
    end

    always_comb
    begin
        logic [2:0] r;
        logic [6:0] p;
        logic wr_fire;
        logic rd_fire;
        logic clr_ovc;
        logic rd_status;
        r = '0;
        p = '0;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        clr_ovc = 1'b0;
        rd_status = 1'b0;
        st_nxt = st_r;
        if (ce)
        begin
            // Bus slave: address and data taken in either order, response after both.
            if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid)
            begin
                st_nxt.aw_got = 1'b1;
                st_nxt.awa = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid)
            begin
                st_nxt.w_got = 1'b1;
                st_nxt.wd = s_axi_wdata;
                st_nxt.ws = s_axi_wstrb;
            end
            wr_fire = st_r.aw_got && st_r.w_got;
            if (wr_fire)
            begin
                st_nxt.aw_got = 1'b0;
                st_nxt.w_got = 1'b0;
                st_nxt.bvalid = 1'b1;
                st_nxt.bresp = 2'h0;
                unique case ({3'h0, st_r.awa})
                    OFS_CTRL: st_nxt.ctrl = byte_merge(st_r.ctrl, st_r.wd, st_r.ws);
                    OFS_CLR: clr_ovc = st_r.ws[1] & st_r.wd[8];
                    OFS_STAT, OFS_POS: ;
                    default: st_nxt.bresp = 2'h2;
                endcase
            end
            if (st_r.bvalid && s_axi_bready)
            begin
                st_nxt.bvalid = 1'b0;
            end
            rd_fire = s_axi_arvalid && !st_r.rvalid;
            if (rd_fire)
            begin
                st_nxt.rvalid = 1'b1;
                st_nxt.rresp = 2'h0;
                unique case ({3'h0, s_axi_araddr})
                    OFS_CTRL: st_nxt.rdata = st_r.ctrl;
                    OFS_STAT:
                    begin
                        st_nxt.rdata = status_word;
                        rd_status = 1'b1;
                    end
                    OFS_POS: st_nxt.rdata = {25'h0, st_r.pos};
                    OFS_CLR: st_nxt.rdata = '0;
                    default:
                    begin
                        st_nxt.rdata = '0;
                        st_nxt.rresp = 2'h2;
                    end
                endcase
            end
            if (st_r.rvalid && s_axi_rready)
            begin
                st_nxt.rvalid = 1'b0;
            end

            // Translator.
            st_nxt.step_d = sy.step;
            if (step_edge)
            begin
                r = res_new;
                p = st_r.pos;
                // Finer grid: land on nearest finer point first; coarser keeps offset.
                if (r < st_r.res_act)
                begin
                    p = snap(p, r);
                end
                // Coarser steps from the current point so any offset stays.
                if (sy.sense)
                begin
                    st_nxt.pos = p + step_of(r);
                end
                else
                begin
                    st_nxt.pos = p - step_of(r);
                end
                st_nxt.res_act = r;
            end

            // Amplitude takes effect only at a PWM period boundary.
            if (pwm_period_start)
            begin
                st_nxt.amp = st_r.ctrl[CTRL_AMP_LO +: 5];
            end

            // Back-EMF monitor.
            st_nxt.zx_d = sy.pins[4];
            st_nxt.zy_d = sy.pins[5];
            st_nxt.smp = 1'b0;
            // Samples taken under the hold strobe stay internal until the crossing ends.
            if (sy.pins[0] & (sy.pins[4] | sy.pins[5]))
            begin
                st_nxt.bhold = scaled;
            end
            if ((st_r.zx_d & ~sy.pins[4]) | (st_r.zy_d & ~sy.pins[5]))
            begin
                st_nxt.smp = 1'b1;
                st_nxt.bemf = sy.pins[0] ? scaled : st_r.bhold;
            end
            if (st_r.ctrl[CTRL_TRANSP])
            begin
                st_nxt.bemf = scaled;
            end

            // Faults.
            st_nxt.tw = temp_warn_in;
            st_nxt.pump = sy.pins[1];
            if (rd_status && !temp_warn_in)
            begin
                st_nxt.thermal_shutdown_flag = 1'b0;
            end
            if (temp_shutdown_in)
            begin
                st_nxt.thermal_shutdown_flag = 1'b1;
            end
            if (clr_ovc)
            begin
                st_nxt.ovcx = '0;
                st_nxt.ovcy = '0;
                st_nxt.open_winding_x = 1'b0;
                st_nxt.open_winding_y = 1'b0;
            end
            st_nxt.ovcx = st_nxt.ovcx | overcurrent_x_in;
            st_nxt.ovcy = st_nxt.ovcy | overcurrent_y_in;
            st_nxt.cntx = sy.pins[2] ? st_r.cntx + 28'h1 : '0;
            st_nxt.cnty = sy.pins[3] ? st_r.cnty + 28'h1 : '0;
            if (st_r.cntx >= 28'(OPEN_CYC))
            begin
                st_nxt.open_winding_x = 1'b1;
                st_nxt.cntx = st_r.cntx;
            end
            if (st_r.cnty >= 28'(OPEN_CYC))
            begin
                st_nxt.open_winding_y = 1'b1;
                st_nxt.cnty = st_r.cnty;
            end
            if (st_r.por_cnt != 12'(POR_CYC))
            begin
                st_nxt.por_cnt = st_r.por_cnt + 12'h1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RESET;
            st_r.res_act <= RES_RESET;
            st_r.amp <= AMP_RESET;
            st_r.pump <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign translator_position = st_r.pos;
    assign peak_amplitude_code = st_r.amp;
    assign backemf_monitor = st_r.bemf;
    assign backemf_sample = st_r.smp;
    assign drive_x_en = ~drv_off & ~st_r.open_winding_x;
    assign drive_y_en = ~drv_off & ~st_r.open_winding_y;
    assign fault_out_n = ~(st_r.tw | st_r.thermal_shutdown_flag | (|st_r.ovcx) | (|st_r.ovcy) | st_r.open_winding_x
        | st_r.open_winding_y | st_r.pump);
    // Open drain: drive low while counting, release afterwards.
    assign power_on_reset_out_n_o = 1'b0;
    assign power_on_reset_out_n_oe = (st_r.por_cnt != 12'(POR_CYC));
    assign s_axi_awready = ce & ~st_r.aw_got & ~st_r.bvalid;
    assign s_axi_wready = ce & ~st_r.w_got & ~st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = ce & ~st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
endmodule // stpd_top

/* dv/stpd_checker.sv */
// Port checker for the stepper translator block, bound to its top module.
`timescale 1ns/1ns
module stpd_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic next_step_input,
    input wire logic temp_warn_in,
    input wire logic temp_shutdown_in,
    input wire logic pump_low_in,
    input wire logic [3:0] overcurrent_x_in,
    input wire logic pwm_period_start,
    input wire logic [6:0] translator_position,
    input wire logic [4:0] peak_amplitude_code,
    input wire logic drive_x_en,
    input wire logic drive_y_en,
    input wire logic fault_out_n,
    input wire logic power_on_reset_out_n_o,
    input wire logic power_on_reset_out_n_oe
);
    import stpd_pkg::*;
    logic [11:0] por_cnt_r;
    logic [11:0] por_cnt_nxt;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Saturating count of cycles with ce high since reset release; a margin of two absorbs pipeline slack.
    always_comb
    begin
        por_cnt_nxt = por_cnt_r;
        if (ce && por_cnt_r != 12'hfff)
            por_cnt_nxt = por_cnt_r + 12'h001;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            por_cnt_r <= 12'h000;
        else
            por_cnt_r <= por_cnt_nxt;
    end
    a_por_hold_low: assert property ((por_cnt_r < POR_CYC - 2) |-> power_on_reset_out_n_oe)
        else $error("reset output released early");
    a_por_open_drain: assert property (!power_on_reset_out_n_o)
        else $error("reset output driven high");
    a_por_release: assert property ((por_cnt_r > POR_CYC + 2) |-> !power_on_reset_out_n_oe)
        else $error("reset output never released");
    a_warn_fault: assert property ($rose(temp_warn_in) |-> ##[1:4] !fault_out_n)
        else $error("warning did not pull fault low");
    a_pump_fault: assert property (pump_low_in [*6] |-> !fault_out_n)
        else $error("pump failure did not pull fault low");
    a_tsd_drv_off: assert property (temp_shutdown_in |-> ##[1:3] !(drive_x_en || drive_y_en))
        else $error("drivers on during shutdown");
    a_ovc_drv_off: assert property ((|overcurrent_x_in) |-> ##[1:3] !(drive_x_en || drive_y_en))
        else $error("drivers on after over-current");
    a_pos_by_step: assert property ($changed(translator_position) |->
        $past(next_step_input, 2) != $past(next_step_input, 5))
        else $error("position moved without a step edge");
    a_amp_at_period: assert property ($changed(peak_amplitude_code) |->
        ($past(pwm_period_start) || $past(pwm_period_start, 2)))
        else $error("amplitude changed outside period start");
endmodule // stpd_checker
bind stpd_top stpd_checker u_stpd_checker (.aclk, .aresetn, .ce, .next_step_input, .temp_warn_in,
    .temp_shutdown_in, .pump_low_in, .overcurrent_x_in, .pwm_period_start, .translator_position,
    .peak_amplitude_code, .drive_x_en, .drive_y_en, .fault_out_n, .power_on_reset_out_n_o,
    .power_on_reset_out_n_oe);

/* dv/stpd_mcu_pins.sv */
// Controller model for the step and rotation sense pins.
`timescale 1ns/1ns
module stpd_mcu_pins
#(
    parameter int GAP = 125000
)
(
    input wire logic aclk,
    input wire logic req,
    input wire logic dir,
    output logic busy,
    output logic next_step_input,
    output logic rotation_sense_input
);
    initial
    begin
        busy = 1'b0;
        next_step_input = 1'b0;
        rotation_sense_input = 1'b1;
    end
    // One request is one edge; the gap after each edge also fences any later sense change.
    task automatic do_edge();
        begin
            busy <= 1'b1;
            if (dir !== rotation_sense_input)
            begin
                rotation_sense_input <= dir;
                repeat (GAP) @(posedge aclk);
            end
            next_step_input <= !next_step_input;
            repeat (GAP) @(posedge aclk);
            busy <= 1'b0;
        end
    endtask
    always @(posedge aclk)
        if (req && !busy)
            do_edge();
endmodule // stpd_mcu_pins

/* dv/testbench.sv */
// Self-checking bench for the stepper translator block.
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
    import stpd_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, req = 1'b0, dir = 1'b1, busy, nxt, sns;
    logic tw = 1'b0, thermal_shutdown_flag = 1'b0, pump = 1'b1, fdx = 1'b0, pps = 1'b0, zcx = 1'b0;
    logic [3:0] ocx = 4'h0, ocy = 4'h0;
    logic [7:0] cv = 8'h00;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [6:0] pos;
    logic [4:0] amp;
    logic [7:0] mon;
    logic smp, dxe, dye, flt, poro, pore, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [1:0] bresp, rresp, rs, bs;
    logic ce = 1'b1, psh = 1'b0;
    int err_total = 0, n_compared = 0, n_smp = 0;
    always @(posedge aclk)
        if (smp === 1'b1)
            n_smp++;
    initial
        forever #2 aclk = ~aclk;
    // The block does not time the sense gap, so a short gap keeps the run brief.
    stpd_mcu_pins #(.GAP(200)) u_stpd_mcu_pins (.aclk(aclk), .req(req), .dir(dir), .busy(busy),
        .next_step_input(nxt), .rotation_sense_input(sns));
    stpd_top u_stpd_top (.aclk(aclk), .aresetn(aresetn), .ce(ce), .next_step_input(nxt),
        .rotation_sense_input(sns), .temp_warn_in(tw), .temp_shutdown_in(thermal_shutdown_flag),
        .pump_low_in(pump), .full_duty_x_in(fdx), .full_duty_y_in(1'b0),
        .pwm_sample_hold(psh), .overcurrent_x_in(ocx), .overcurrent_y_in(ocy),
        .pwm_period_start(pps), .zero_cross_x(zcx), .zero_cross_y(1'b0), .coil_voltage(cv),
        .translator_position(pos), .peak_amplitude_code(amp), .backemf_monitor(mon),
        .backemf_sample(smp), .drive_x_en(dxe), .drive_y_en(dye), .fault_out_n(flt),
        .power_on_reset_out_n_o(poro), .power_on_reset_out_n_oe(pore),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        begin
            awaddr <= a[4:0];
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (awrdy)
                    awvalid <= 1'b0;
                if (wrdy)
                    wvalid <= 1'b0;
            end while (!bvalid);
            bs = bresp;
            bready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task automatic rdr(input logic [7:0] a);
        begin
            araddr <= a[4:0];
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (arrdy)
                    arvalid <= 1'b0;
            end while (!rvalid);
            rd = rdata;
            rs = rresp;
            rready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task automatic edge1(input logic u);
        begin
            dir <= u;
            req <= 1'b1;
            @(posedge aclk);
            while (!busy)
                @(posedge aclk);
            req <= 1'b0;
            while (busy)
                @(posedge aclk);
        end
    endtask
    task automatic pulse(input logic u);
        begin
            edge1(u);
            edge1(u);
        end
    endtask
    task automatic t_reset();
        begin
            `CHK("por_oe", 1'b1, pore)
            @(posedge aclk);
            `CHK("fault_n", 1'b0, flt)
            rdr(OFS_CTRL);
            `CHK("ctrl", CTRL_RESET, rd)
            repeat (8) @(posedge aclk);
            `CHK("fault_n", 1'b0, flt)
            pump <= 1'b0;
            repeat (8) @(posedge aclk);
            `CHK("fault_n", 1'b1, flt)
            $display("test reset done");
        end
    endtask
    task automatic t_step();
        begin
            repeat (3) pulse(1'b1);
            `CHK("pos", 7'h03, pos)
            repeat (4) pulse(1'b0);
            rdr(OFS_POS);
            `CHK("pos", 7'h7f, rd[6:0])
            pulse(1'b1);
            `CHK("pos", 7'h00, pos)
            wr(OFS_CTRL, 32'h0);
            edge1(1'b1);
            `CHK("pos rise", 7'h00, pos)
            edge1(1'b1);
            `CHK("pos fall", 7'h01, pos)
            $display("test step done");
        end
    endtask
    task automatic t_res();
        begin
            wr(OFS_CTRL, 32'h22);
            `CHK("pos", 7'h01, pos)
            pulse(1'b1);
            `CHK("pos", 7'h05, pos)
            wr(OFS_CTRL, 32'h12);
            pulse(1'b1);
            `CHK("pos", 7'h08, pos)
            wr(OFS_CTRL, 32'h22);
            pulse(1'b1);
            `CHK("pos", 7'h0c, pos)
            wr(OFS_CTRL, CTRL_RESET);
            pulse(1'b0);
            `CHK("pos", 7'h0b, pos)
            $display("test resolution done");
        end
    endtask
    task automatic t_amp_bemf();
        begin
            wr(OFS_CTRL, 32'h1506);
            cv <= 8'hc8;
            repeat (6) @(posedge aclk);
            `CHK("amp", 5'h00, amp)
            `CHK("mon", 8'h64, mon)
            pps <= 1'b1;
            @(posedge aclk);
            pps <= 1'b0;
            repeat (3) @(posedge aclk);
            `CHK("amp", 5'h15, amp)
            wr(OFS_CTRL, 32'h150e);
            repeat (6) @(posedge aclk);
            `CHK("mon", 8'h32, mon)
            wr(OFS_CTRL, 32'h150a);
            cv <= 8'h40;
            repeat (6) @(posedge aclk);
            `CHK("mon hold", 8'h32, mon)
            zcx <= 1'b1;
            psh <= 1'b1;
            repeat (6) @(posedge aclk);
            `CHK("mon mid", 8'h32, mon)
            psh <= 1'b0;
            repeat (4) @(posedge aclk);
            cv <= 8'h80;
            repeat (2) @(posedge aclk);
            zcx <= 1'b0;
            repeat (8) @(posedge aclk);
            `CHK("mon", 8'h10, mon)
            `CHK("samples", 32'd1, n_smp)
            $display("test amplitude and monitor done");
        end
    endtask
    task automatic t_fault();
        begin
            tw <= 1'b1;
            fdx <= 1'b1;
            repeat (12) @(posedge aclk);
            `CHK("fault_n", 1'b0, flt)
            `CHK("drv", 2'b11, {dxe, dye})
            fdx <= 1'b0;
            thermal_shutdown_flag <= 1'b1;
            @(posedge aclk);
            thermal_shutdown_flag <= 1'b0;
            rdr(OFS_STAT);
            rdr(OFS_STAT);
            `CHK("tw tsd", 2'b11, rd[1:0])
            `CHK("drv", 2'b00, {dxe, dye})
            tw <= 1'b0;
            repeat (3) @(posedge aclk);
            rdr(OFS_STAT);
            rdr(OFS_STAT);
            `CHK("tsd", 1'b0, rd[ST_TSD])
            ocx <= 4'h2;
            ocy <= 4'h8;
            @(posedge aclk);
            ocx <= 4'h0;
            ocy <= 4'h0;
            rdr(OFS_STAT);
            `CHK("ovc", 8'h82, rd[15:8])
            `CHK("drv", 2'b00, {dxe, dye})
            `CHK("fault_n", 1'b0, flt)
            wr(OFS_CLR, 32'h100);
            `CHK("drv", 2'b11, {dxe, dye})
            `CHK("fault_n", 1'b1, flt)
            rdr(8'h10);
            `CHK("rresp", 2'b10, rs)
            wr(8'h14, 32'h1);
            `CHK("bresp", 2'b10, bs)
            $display("test faults done");
        end
    endtask
    task automatic t_freeze();
        begin
            `CHK("por_oe", 1'b0, pore)
            wr(OFS_CTRL, 32'h0902);
            ce <= 1'b0;
            pps <= 1'b1;
            @(posedge aclk);
            pps <= 1'b0;
            repeat (3) @(posedge aclk);
            `CHK("amp frozen", 5'h15, amp)
            `CHK("awready", 1'b0, awrdy)
            ce <= 1'b1;
            pps <= 1'b1;
            @(posedge aclk);
            pps <= 1'b0;
            repeat (3) @(posedge aclk);
            `CHK("amp", 5'h09, amp)
            aresetn <= 1'b0;
            repeat (10) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (2) @(posedge aclk);
            `CHK("pos", 7'h00, pos)
            `CHK("por_oe", 1'b1, pore)
            `CHK("fault_n", 1'b0, flt)
            $display("test freeze and reset done");
        end
    endtask
    task automatic report_and_stop();
        begin
            $display("compared %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial
    begin
        #240000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_step();
        t_res();
        t_amp_bemf();
        t_fault();
        t_freeze();
        report_and_stop();
    end
endmodule // testbench
